// *** osd_defines.svh ***
// osd_defines.svh: constants for the display-side pin block
// assumes: included by the package, osd_host_port and the testbench by bare name
// Notes on behaviour
// (RQ1) serial data in is sampled on each rising serial clock edge while chip select is low.
// (RQ2) serial data out changes on each falling serial clock edge.
// (RQ3) chip select is active low and serial data out is released while it is high.
// (RQ4) the host keeps the serial clock duty cycle between 40% and 60%.
// (RQ5) the sync-lost flag rises after 32 consecutive lines without a sync pulse.
// (RQ6) the sync-lost flag falls only after 32 consecutive valid sync pulses.
// (RQ7) sync-lost, vertical and horizontal sync outputs are open drain.
// (RQ8) vertical sync out goes low following the vertical sync interval.
// (RQ9) horizontal sync out goes low following each horizontal sync interval.
// (RQ10) sync outputs follow the video input, or the internal generator in internal mode.
// (RQ11) the system clock is presented as a buffered clock output.
// (RQ12) the system supplies a crystal or a direct reference clock.
// (RQ13) the host holds reset low for at least 50 ms; the testbench holds it low for 10 clock cycles.
// (RQ14) all serial registers return to defaults within 100 us of reset release.
// (RQ15) no register access is honoured during the initialisation period.
// (RQ16) all display memory locations clear to 00H within 20 us of reset release.
// (RQ17) the serial bit counter restarts whenever chip select rises.
`ifndef OSD_DEFINES_SVH
`define OSD_DEFINES_SVH
`define CLK_SYS_HZ      10000000
`define REG_INIT_NS     100000
`define MEM_CLEAR_NS    20000
`define REG_INIT_CYC    ((`REG_INIT_NS / 1000) * (`CLK_SYS_HZ / 1000000))
`define MEM_CLEAR_CYC   ((`MEM_CLEAR_NS / 1000) * (`CLK_SYS_HZ / 1000000))
`define SYNC_RUN_LEN    32
`define LINE_LEN_CYC    636
`define HSYNC_LEN_CYC   47
`define FRAME_LINES     525
`define VSYNC_LINES     3
`define LINE_TIMEOUT    1272
`define MEM_DEPTH       480
`define MEM_INIT        8'h00
`define NUM_REGS        16
`define REG_INIT        8'h00
`endif

// *** osd_pkg.sv ***
// osd_pkg: types shared by the pin block
// assumes: nothing beyond the defines header
`include "osd_defines.svh"
package osd_pkg;
    typedef enum logic [1:0] {INIT_MEM, INIT_REG, READY} init_state_e;
    typedef enum logic [1:0] {SPI_CMD, SPI_DATA, SPI_IDLE} spi_state_e;
endpackage

// *** osd_sync2.sv ***
// osd_sync2: two-flop level synchroniser
// assumes: d_i comes from another domain
`timescale 1ns/100ps
module osd_sync2 (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // osd_sync2

// *** osd_serial_link.sv ***
// osd_serial_link: shift logic on the host serial clock
// assumes: cs_b_i high between transactions; frame 16 bits: a7 r/w, addr, data
`timescale 1ns/100ps
module osd_serial_link (
    // reset
    input  wire logic       rst_b_i,
    // link pins
    input  wire logic       sclk_i,
    input  wire logic       cs_b_i,
    input  wire logic       serial_data_in_i,
    output logic            serial_data_out_o,
    output logic            serial_data_out_oe_o,
    // to core
    output logic [15:0]     frame_o,
    output logic            frame_tgl_o,
    input  wire logic [7:0] rd_data_i
);
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    logic [7:0]  out_shift;
    // counter reset by chip select high restarts each transaction
    always_ff @(posedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            bit_cnt <= 4'h0;                    // RQ17
            shift   <= 16'h0000;
        end else begin
            shift   <= {shift[14:0], serial_data_in_i}; // RQ1
            bit_cnt <= bit_cnt + 4'h1;
        end
    end
    // full frame held and flagged by toggle for the core domain
    // toggle resets with the core, so a stale level never reads as a new frame
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_o     <= 16'h0000;
            frame_tgl_o <= 1'b0;
        end else if (!cs_b_i && (bit_cnt == 4'hF)) begin
            frame_o     <= {shift[14:0], serial_data_in_i};
            frame_tgl_o <= ~frame_tgl_o;
        end
    end
    // read data shifts out on falling edge; rd_data_i is stable during frame
    always_ff @(negedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            out_shift <= 8'h00;
        end else if (bit_cnt == 4'h8) begin
            out_shift <= rd_data_i;             // RQ2
        end else begin
            out_shift <= {out_shift[6:0], 1'b0}; // RQ2
        end
    end
    assign serial_data_out_o    = out_shift[7];
    assign serial_data_out_oe_o = ~cs_b_i;      // RQ3
endmodule // osd_serial_link

// *** osd_host_port.sv ***
// osd_host_port: serial port, reset initialisation, sync outputs and clock buffer
// assumes: CLK_SYS_I is the reference clock; video sync arrives as a digital pulse
`timescale 1ns/100ps
`include "osd_defines.svh"
module osd_host_port
    import osd_pkg::*;
#(
    parameter int REG_INIT_CYC  = `REG_INIT_CYC,
    parameter int MEM_CLEAR_CYC = `MEM_CLEAR_CYC,
    parameter int LINE_LEN_CYC  = `LINE_LEN_CYC
) (
    // system
    input  wire logic CLK_SYS_I,
    input  wire logic RST_B_I,
    output logic      BUFFERED_CLOCK_OUTPUT_O,
    // serial link
    input  wire logic SCLK_I,
    input  wire logic CS_B_I,
    input  wire logic SERIAL_DATA_IN_I,
    output logic      SERIAL_DATA_OUT_O,
    output logic      SERIAL_DATA_OUT_OE_O,
    // video timing
    input  wire logic VIDEO_SYNC_I,
    input  wire logic VIDEO_VSYNC_I,
    input  wire logic INTERNAL_SYNC_I,
    // open-drain outputs: pin value is 0 when enabled; READY_O is a plain output
    output logic      SYNC_LOST_FLAG_O,
    output logic      SYNC_LOST_FLAG_OE_O,
    output logic      VSYNC_B_O,
    output logic      VSYNC_B_OE_O,
    output logic      HSYNC_B_O,
    output logic      HSYNC_B_OE_O,
    output logic      READY_O
);
    //////////////////////////////////////////////////////////////////////////////////
    init_state_e init_state;
    logic [15:0] init_cnt;
    logic [7:0]  regs [`NUM_REGS];
    logic [7:0]  mem  [`MEM_DEPTH];
    logic [15:0] frame;
    logic        frame_tgl, tgl_s, tgl_d;
    logic [7:0]  rd_data;
    logic        vid_sync, vid_vsync, sync_d;
    logic [10:0] line_cnt;
    logic [5:0]  miss_cnt, good_cnt;
    logic        lost;
    logic [9:0]  h_cnt;
    logic [9:0]  v_line;
    logic        int_h, int_v;
    logic        int_sel;

    assign BUFFERED_CLOCK_OUTPUT_O = CLK_SYS_I;  // RQ11

    osd_serial_link link (
        .rst_b_i              (RST_B_I),
        .sclk_i               (SCLK_I),
        .cs_b_i               (CS_B_I),
        .serial_data_in_i     (SERIAL_DATA_IN_I),
        .serial_data_out_o    (SERIAL_DATA_OUT_O),
        .serial_data_out_oe_o (SERIAL_DATA_OUT_OE_O),
        .frame_o              (frame),
        .frame_tgl_o          (frame_tgl),
        .rd_data_i            (rd_data)
    );
    osd_sync2 s_tgl (.clk_i(CLK_SYS_I), .rst_b_i(RST_B_I), .d_i(frame_tgl), .q_o(tgl_s));
    osd_sync2 s_syn (.clk_i(CLK_SYS_I), .rst_b_i(RST_B_I), .d_i(VIDEO_SYNC_I), .q_o(vid_sync));
    osd_sync2 s_vs  (.clk_i(CLK_SYS_I), .rst_b_i(RST_B_I), .d_i(VIDEO_VSYNC_I), .q_o(vid_vsync));
    osd_sync2 s_int (.clk_i(CLK_SYS_I), .rst_b_i(RST_B_I), .d_i(INTERNAL_SYNC_I), .q_o(int_sel));

    //////////////////////////////////////////////////////////////////////////////////
    // init sequence: memory and registers are restored in the first window;
    // the rest of the register window only locks out the link
    // one counter from release, so READY_O rises REG_INIT_CYC edges after it
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            init_state <= INIT_MEM;
            init_cnt   <= 16'h0000;
        end else begin
            case (init_state)
                INIT_MEM: begin
                    init_cnt <= init_cnt + 16'h0001;
                    if (init_cnt == 16'(MEM_CLEAR_CYC - 1)) begin
                        init_state <= INIT_REG;
                    end
                end
                INIT_REG: begin
                    init_cnt <= init_cnt + 16'h0001;
                    if (init_cnt == 16'(REG_INIT_CYC - 1)) begin
                        init_state <= READY;
                    end
                end
                default: init_state <= READY;
            endcase
        end
    end
    assign READY_O = (init_state == READY);

    // frame toggle edge; frame word stable long before edge arrives here
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tgl_d <= 1'b0;
        end else begin
            tgl_d <= tgl_s;
        end
    end

    // whole memory cleared each cycle of the window: wide, but well inside the bound
    always_ff @(posedge CLK_SYS_I) begin
        if (init_state == INIT_MEM) begin
            for (int i = 0; i < `MEM_DEPTH; i++) begin
                mem[i] <= `MEM_INIT;            // RQ16
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (init_state == INIT_MEM) begin
            for (int i = 0; i < `NUM_REGS; i++) begin
                regs[i] <= `REG_INIT;           // RQ14
            end
        end else if (READY_O && (tgl_s != tgl_d) && !frame[15]) begin
            regs[frame[11:8]] <= frame[7:0];    // RQ15
        end
    end

    // reads ignored until ready; rd_data only changes between frames
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rd_data <= 8'h00;
        end else if (READY_O && (tgl_s != tgl_d) && frame[15]) begin
            rd_data <= regs[frame[11:8]];       // RQ15
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // loss-of-sync: line windows without sync versus runs of good pulses
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sync_d   <= 1'b0;
            line_cnt <= 11'h000;
            miss_cnt <= 6'h00;
            good_cnt <= 6'h00;
            lost     <= 1'b1;
        end else begin
            sync_d <= vid_sync;
            if (vid_sync && !sync_d) begin
                line_cnt <= 11'h000;
                miss_cnt <= 6'h00;
                if (good_cnt == 6'(`SYNC_RUN_LEN - 1)) begin
                    lost <= 1'b0;               // RQ6
                end else begin
                    good_cnt <= good_cnt + 6'h01;
                end
            end else if (line_cnt == 11'(LINE_LEN_CYC - 1)) begin
                line_cnt <= 11'h000;
                good_cnt <= 6'h00;
                if (miss_cnt == 6'(`SYNC_RUN_LEN - 1)) begin
                    lost <= 1'b1;               // RQ5
                end else begin
                    miss_cnt <= miss_cnt + 6'h01;
                end
            end else begin
                line_cnt <= line_cnt + 11'h001;
            end
        end
    end

    // internal timing generator
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            h_cnt  <= 10'h000;
            v_line <= 10'h000;
        end else if (h_cnt == 10'(LINE_LEN_CYC - 1)) begin
            h_cnt  <= 10'h000;
            v_line <= (v_line == 10'(`FRAME_LINES - 1)) ? 10'h000 : v_line + 10'h001;
        end else begin
            h_cnt <= h_cnt + 10'h001;
        end
    end
    assign int_h = (h_cnt < 10'(`HSYNC_LEN_CYC));
    assign int_v = (v_line < 10'(`VSYNC_LINES));

    // outputs registered; open drain drives only low
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SYNC_LOST_FLAG_OE_O <= 1'b0;
            HSYNC_B_OE_O        <= 1'b0;
            VSYNC_B_OE_O        <= 1'b0;
        end else begin
            SYNC_LOST_FLAG_OE_O <= !lost;                                    // RQ7
            // outside internal mode every recovered pulse is passed on and with no video the pins stay released
            HSYNC_B_OE_O <= int_sel ? int_h : vid_sync;    // RQ9 RQ10
            VSYNC_B_OE_O <= int_sel ? int_v : vid_vsync;   // RQ8 RQ10
        end
    end
    assign SYNC_LOST_FLAG_O = 1'b0;
    assign HSYNC_B_O        = 1'b0;
    assign VSYNC_B_O        = 1'b0;

    //////////////////////////////////////////////////////////////////////////////////
    lost_rise_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        $rose(lost) |-> $past(miss_cnt) == 6'(`SYNC_RUN_LEN - 1))
        else $error("sync lost raised early"); // RQ5
    lost_fall_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        $fell(lost) |-> $past(good_cnt) == 6'(`SYNC_RUN_LEN - 1))
        else $error("sync lost cleared early"); // RQ6
    los_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        ##1 SYNC_LOST_FLAG_OE_O == !$past(lost))
        else $error("sync lost pin mismatch"); // RQ7
    hs_int_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        int_sel && int_h |=> HSYNC_B_OE_O)
        else $error("hsync not driven"); // RQ9
    vs_int_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        int_sel && int_v |=> VSYNC_B_OE_O)
        else $error("vsync not driven"); // RQ8
    ext_follow_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !int_sel |=> (HSYNC_B_OE_O == $past(vid_sync)) && (VSYNC_B_OE_O == $past(vid_vsync)))
        else $error("sync outputs not following video"); // RQ10
    ready_time_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        $rose(RST_B_I) |-> ##[1:REG_INIT_CYC] READY_O)
        else $error("init too slow"); // RQ14
    no_access_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !READY_O |=> $stable(rd_data))
        else $error("read during init"); // RQ15
    mem_done_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        init_state == INIT_REG |-> (mem[0] == `MEM_INIT) && (mem[`MEM_DEPTH - 1] == `MEM_INIT))
        else $error("memory not cleared"); // RQ16
    cs_tri_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        SERIAL_DATA_OUT_OE_O == !CS_B_I)
        else $error("data out enable wrong"); // RQ3
    ready_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) $rose(READY_O));
    lost_c:  cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) $fell(lost));
    frame_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) tgl_s != tgl_d);
endmodule // osd_host_port

// *** host_model.sv ***
// host_model: behavioural host controller driving the serial port
// assumes: xfer itself spaces frames; the serial clock stands low between frames
`timescale 1ns/100ps
module host_model (
    // serial link
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // one chip-select rise at start puts the link's bit counter in a known state
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b0;
        mosi_o = 1'b0;
        #10;
        cs_b_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    // msb first; a short bit count sends a partial frame that chip select high discards
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        cs_b_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi_o = tx[15 - i];
            #62.5;
            sclk_o = 1'b1;
            rx = {rx[14:0], miso_i};
            #62.5;
            sclk_o = 1'b0;
        end
        #40;
        cs_b_o = 1'b1;
        // released line: show the inverse so a stale value never looks valid
        mosi_o = ~mosi_o;
        // gap covers the chip-select high time and the core's frame spacing
        #600;
    endtask
endmodule // host_model

// *** testbench.sv ***
// testbench: scenarios for the pin block with a host model on the serial port
// assumes: design parameters shortened; frame is r/w, pad, reg, data
`timescale 1ns/100ps
`include "osd_defines.svh"
module testbench;
    import osd_pkg::*;
    // register window long enough that an early frame ends inside it
    localparam int MEMC = 8;
    localparam int REGC = 40;
    localparam int LINEC = 64;
    logic clk = 1'b0;
    // idle high so the first reset is a real falling edge for the link side
    logic rst_b = 1'b1;
    logic hs_in = 1'b0;
    logic vs_in = 1'b0;
    logic int_sync = 1'b0;
    logic clk_buf, sdo, sdo_oe, sync_lost_flag, los_oe, vs, vs_oe, hs, hs_oe, ready;
    logic sclk, cs_b, mosi, miso;
    logic [15:0] rx;
    logic [7:0]  rd;
    int miscompares = 0;
    int total_checks = 0;
    wire los_pin = los_oe ? sync_lost_flag : 1'b1;
    wire vs_pin  = vs_oe ? vs : 1'b1;
    wire hs_pin  = hs_oe ? hs : 1'b1;
    // released line shows the inverse so a stale value never looks valid
    assign miso = sdo_oe ? sdo : ~sdo;
    always #50 clk = ~clk;
    host_model host (.sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));
    osd_host_port #(.REG_INIT_CYC(REGC), .MEM_CLEAR_CYC(MEMC), .LINE_LEN_CYC(LINEC)) dut (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .BUFFERED_CLOCK_OUTPUT_O(clk_buf),
        .SCLK_I(sclk), .CS_B_I(cs_b), .SERIAL_DATA_IN_I(mosi),
        .SERIAL_DATA_OUT_O(sdo), .SERIAL_DATA_OUT_OE_O(sdo_oe),
        .VIDEO_SYNC_I(hs_in), .VIDEO_VSYNC_I(vs_in), .INTERNAL_SYNC_I(int_sync),
        .SYNC_LOST_FLAG_O(sync_lost_flag), .SYNC_LOST_FLAG_OE_O(los_oe), .VSYNC_B_O(vs),
        .VSYNC_B_OE_O(vs_oe), .HSYNC_B_O(hs), .HSYNC_B_OE_O(hs_oe), .READY_O(ready));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer({4'h0, a, d}, 16, rx);
    endtask
    // second frame carries the answer of the first
    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        host.xfer({4'h8, a, 8'h00}, 16, rx);
        host.xfer({4'h8, a, 8'h00}, 16, rx);
        d = rx[7:0];
    endtask
    // data out enabled at each serial clock rise, which only comes while selected
    always @(posedge sclk) check(sdo_oe, !cs_b);
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset(input logic early);
        cycles(1);
        rst_b = 1'b0;
        cycles(10);
        check({ready, los_pin, hs_pin, vs_pin}, 4'h7);
        rst_b = 1'b1;
        if (early) begin
            wr(4'h2, 8'h5A);
            check(ready, 1'b0);
            cycles(REGC);
        end else begin
            cycles(REGC - 2);
            check(ready, 1'b0);
            cycles(4);
        end
        check(ready, 1'b1);
        check(sdo_oe, 1'b0);
        if (early) begin
            rdr(4'h2, rd);
            check(rd, 8'h00);
        end
    endtask
    task automatic t_regs;
        logic [3:0] a [3] = '{4'h0, 4'h7, 4'hF};
        foreach (a[i]) begin
            wr(a[i], 8'hA5 ^ {a[i], a[i]});
            rdr(a[i], rd);
            check(rd, 8'hA5 ^ {a[i], a[i]});
        end
    endtask
    task automatic t_partial;
        host.xfer(16'h8FFF, 5, rx);
        wr(4'h4, 8'h3C);
        rdr(4'h4, rd);
        check(rd, 8'h3C);
    endtask
    task automatic t_mid_reset;
        wr(4'h9, 8'h77);
        t_reset(1'b0);
        rdr(4'h9, rd);
        check(rd, 8'h00);
    endtask
    task automatic t_lost;
        repeat (32) begin
            check(los_pin, 1'b1);
            hs_in = 1'b1;
            cycles(4);
            check(hs_pin, 1'b0);
            hs_in = 1'b0;
            cycles(LINEC - 8);
            check(hs_pin, 1'b1);
        end
        cycles(4);
        check(los_pin, 1'b0);
        cycles(LINEC * 28);
        check(los_pin, 1'b0);
        cycles(LINEC * 8);
        check(los_pin, 1'b1);
    endtask
    task automatic t_vsync_clk;
        vs_in = 1'b1;
        cycles(4);
        check({vs_pin, clk_buf, clk}, 3'h3);
        vs_in = 1'b0;
        cycles(6);
        @(negedge clk);
        #5;
        check({vs_pin, clk_buf, clk}, 3'h4);
        cycles(1);
    endtask
    task automatic t_internal;
        int n;
        n = 0;
        int_sync = 1'b1;
        while (hs_pin !== 1'b0 && n < LINEC * 3) begin
            cycles(1);
            n++;
        end
        check(hs_pin, 1'b0);
        // end of a pulse, then count the released part of one line
        n = 0;
        while (hs_pin !== 1'b1 && n < LINEC * 3) begin
            cycles(1);
            n++;
        end
        n = 0;
        while (hs_pin !== 1'b0 && n < LINEC * 3) begin
            cycles(1);
            n++;
        end
        check(n, LINEC - `HSYNC_LEN_CYC);
        int_sync = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #3000000;
        miscompares++;
        complete_run;
    end
    initial begin
        t_reset(1'b1);
        t_regs;
        t_partial;
        t_mid_reset;
        t_lost;
        t_vsync_clk;
        t_internal;
        complete_run;
    end
endmodule // testbench
